// >>> core/sre_pkg.sv
// Shared constants and types for the serial EEPROM slave, reads and writes.
// Assumes a 100 MHz reference clock and a two-wire bus clocked by the controller.
package sre_pkg;

	// ********************************
	// Memory geometry
	// ********************************
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 6;
	localparam int BUF_DEPTH = 2;

	// ********************************
	// Protocol fields and counts
	// ********************************
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	// ********************************
	// Timing
	// ********************************
	localparam int REF_CLK_HZ = 100000000;
	localparam int T_WR_MS = 5;
	// Longest time, so the division rounds down
	localparam int WR_CYCLES = T_WR_MS * (REF_CLK_HZ / 1000);

	typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_WADDR_HI, ST_WADDR_LO, ST_WDATA, ST_READ} sre_state_t;

endpackage

// >>> core/sre_fifo2.sv
// Small FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock; the flush overrides push and pop in the same cycle.
`timescale 1ns/100ps
module sre_fifo2 #(
	parameter int W = 8,
	parameter int DEPTH = sre_pkg::BUF_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	import sre_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] buf_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	// ********************************
	// Handshake
	// ********************************
	assign o_in_ready = (cnt_q != CW'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = buf_q[rd_ptr_q];
	assign push = i_in_valid && o_in_ready && !i_flush;
	assign pop = o_out_valid && i_out_ready && !i_flush;

	// Storage, no reset needed on data
	always_ff @(posedge i_clk)
	begin
		if (i_ce && push)
			buf_q[wr_ptr_q] <= i_in_data;
	end

	// Pointers and fill level
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end
		else if (i_ce)
		begin
			if (i_flush)
			begin
				wr_ptr_q <= '0;
				rd_ptr_q <= '0;
				cnt_q <= '0;
			end
			else
			begin
				if (push)
					wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
				if (pop)
					rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
				if (push && !pop)
					cnt_q <= cnt_q + 1'b1;
				else if (pop && !push)
					cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

// >>> core/sre_eeprom.sv
// Two-wire serial EEPROM slave: address match, reads, writes and write-cycle timer.
// Assumes the controller owns the serial clock; SDA is open drain, resolved outside.
`timescale 1ns/100ps
module sre_eeprom #(
	parameter int ADDR_W = sre_pkg::ADDR_W,
	parameter int WR_CYCLES = sre_pkg::WR_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_hardwired_addr_pin_2,
	input wire logic i_hardwired_addr_pin_1,
	input wire logic i_hardwired_addr_pin_0,
	output logic o_write_busy
);
	import sre_pkg::*;

	localparam int DEPTH = 1 << ADDR_W;
	localparam int CW = $clog2(WR_CYCLES + 1);

	sre_state_t state_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] tx_q;
	logic ack_q;
	logic rw_q;
	logic oe_q;
	logic dirty_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] fp_q;
	logic [7:0] mem_q [DEPTH];
	logic start_tgl_q, start_seen_q, stop_tgl_q, stop_seen_q;
	logic [2:0] pin1_q, pin2_q;
	logic done_s1_q, done_s2_q, done_seen_q;
	logic stop_r1_q, stop_r2_q, stop_r3_q, dirty_r1_q, dirty_r2_q;
	logic busy_q, done_tgl_q, served_q;
	logic [CW-1:0] wr_cnt_q;
	logic start_pend, stop_pend, dev_match, pop, flush, fetch, buf_ready, buf_valid;
	logic [7:0] byte_in, buf_data;
	logic [ADDR_W-1:0] addr_page_inc;

	// ********************************
	// Bus condition detection
	// ********************************
	// SDA edges while SCL high; read at the next rising SCL edge, after the falling edge that follows
	always_ff @(negedge i_sda_in or negedge i_rst_n)
	begin
		if (!i_rst_n)
			start_tgl_q <= 1'b0;
		else if (i_scl && i_ce)
			start_tgl_q <= ~start_tgl_q;
	end

	always_ff @(posedge i_sda_in or negedge i_rst_n)
	begin
		if (!i_rst_n)
			stop_tgl_q <= 1'b0;
		else if (i_scl && i_ce)
			stop_tgl_q <= ~stop_tgl_q;
	end

	// Address pins and write-cycle completion cross into the link domain
	always_ff @(posedge i_scl or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin1_q <= 3'h0;
			pin2_q <= 3'h0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end
		else if (i_ce)
		begin
			pin1_q <= {i_hardwired_addr_pin_2, i_hardwired_addr_pin_1, i_hardwired_addr_pin_0};
			pin2_q <= pin1_q;
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
		end
	end

	// ********************************
	// Link decode
	// ********************************
	assign start_pend = start_tgl_q ^ start_seen_q;
	assign stop_pend = stop_tgl_q ^ stop_seen_q;
	assign byte_in = {sh_q[6:0], i_sda_in};
	assign dev_match = (byte_in[7:4] == DEV_TYPE) && (byte_in[3:1] == pin2_q);
	assign addr_page_inc = {addr_q[ADDR_W-1:PAGE_W], addr_q[PAGE_W-1:0] + 1'b1};
	// Load the shifter on read-address ack or on controller ack
	assign pop = i_ce && !start_pend && !stop_pend && (bit_q == BIT_ACK) &&
		((state_q == ST_DEVADDR && ack_q && rw_q) || (state_q == ST_READ && !i_sda_in));
	// Prefetched bytes go stale when the counter is reloaded or written through
	assign flush = !start_pend && (((state_q == ST_WADDR_LO || state_q == ST_WDATA) && bit_q == BIT_LAST) ||
		(state_q == ST_READ && bit_q == BIT_ACK && i_sda_in));
	assign fetch = buf_ready && !flush;

	sre_fifo2 #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
		.i_clk(i_scl),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_flush(flush),
		.i_in_valid(1'b1),
		.o_in_ready(buf_ready),
		.i_in_data(mem_q[fp_q]),
		.o_out_valid(buf_valid),
		.o_out_data(buf_data),
		.i_out_ready(pop)
	);

	// Array; writes land at once, the write-cycle timer only models the busy time
	always_ff @(posedge i_scl)
	begin
		if (i_ce && !start_pend && state_q == ST_WDATA && bit_q == BIT_LAST)
			mem_q[addr_q] <= byte_in;
	end

	// ********************************
	// Link state machine
	// ********************************
	always_ff @(posedge i_scl or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= IDLE_BYTE;
			ack_q <= 1'b0;
			rw_q <= 1'b0;
			dirty_q <= 1'b0;
			addr_q <= '0;
			fp_q <= '0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
			done_seen_q <= 1'b0;
		end
		else if (i_ce)
		begin
			if (fetch)
				fp_q <= fp_q + 1'b1; // Wraps with the counter
			// Completion clears the busy mark; a new write sets it again
			if (done_s2_q ^ done_seen_q)
			begin
				done_seen_q <= done_s2_q;
				dirty_q <= 1'b0;
			end
			if (start_pend)
			begin
				// This edge carries the first address bit
				start_seen_q <= start_tgl_q;
				stop_seen_q <= stop_tgl_q;
				state_q <= ST_DEVADDR;
				bit_q <= BIT_FIRST;
				sh_q <= {7'h00, i_sda_in};
				ack_q <= 1'b0;
			end
			else if (stop_pend)
			begin
				stop_seen_q <= stop_tgl_q;
				state_q <= ST_IDLE;
				ack_q <= 1'b0;
			end
			else if (state_q != ST_IDLE && bit_q != BIT_ACK)
			begin
				sh_q <= byte_in;
				bit_q <= bit_q + 1'b1;
				if (bit_q == BIT_LAST)
				begin
					unique case (state_q)
						ST_DEVADDR:
						begin
							ack_q <= dev_match && !dirty_q;
							rw_q <= byte_in[0];
						end
						ST_WADDR_HI:
						begin
							ack_q <= 1'b1;
							addr_q[ADDR_W-1:8] <= byte_in[ADDR_W-9:0];
						end
						ST_WADDR_LO:
						begin
							ack_q <= 1'b1;
							addr_q[7:0] <= byte_in;
							fp_q <= {addr_q[ADDR_W-1:8], byte_in};
						end
						ST_WDATA:
						begin
							ack_q <= 1'b1;
							dirty_q <= 1'b1;
							addr_q <= addr_page_inc;
							fp_q <= addr_page_inc;
						end
						ST_READ:
						begin
							ack_q <= 1'b0;
						end
						ST_IDLE:
						begin
							ack_q <= 1'b0;
						end
					endcase
				end
			end
			else if (state_q != ST_IDLE)
			begin
				// Acknowledge slot
				bit_q <= 4'h0;
				ack_q <= 1'b0;
				unique case (state_q)
					ST_DEVADDR:
						state_q <= !ack_q ? ST_IDLE : (rw_q ? ST_READ : ST_WADDR_HI);
					ST_WADDR_HI:
						state_q <= ST_WADDR_LO;
					ST_WADDR_LO:
						state_q <= ST_WDATA;
					ST_WDATA:
						state_q <= ST_WDATA;
					ST_READ:
					begin
						if (i_sda_in)
						begin
							state_q <= ST_IDLE;
							fp_q <= addr_q;
						end
					end
					ST_IDLE:
						state_q <= ST_IDLE;
				endcase
				if (pop)
				begin
					tx_q <= buf_valid ? buf_data : IDLE_BYTE;
					addr_q <= addr_q + 1'b1;
				end
			end
		end
	end

	// Drive on the falling edge so data is stable before the rising edge
	always_ff @(negedge i_scl or negedge i_rst_n)
	begin
		if (!i_rst_n)
			oe_q <= 1'b0;
		else if (i_ce)
			oe_q <= (state_q == ST_READ && bit_q < BIT_ACK && !tx_q[3'(BIT_LAST - bit_q)]) ||
				(bit_q == BIT_ACK && ack_q);
	end

	assign o_sda_oe = oe_q;
	assign o_sda_out = 1'b0;

	// ********************************
	// Write-cycle timer
	// ********************************
	// Stop event and write mark arrive through two flops each
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			stop_r1_q <= 1'b0;
			stop_r2_q <= 1'b0;
			stop_r3_q <= 1'b0;
			dirty_r1_q <= 1'b0;
			dirty_r2_q <= 1'b0;
		end
		else if (i_ce)
		begin
			stop_r1_q <= stop_tgl_q;
			stop_r2_q <= stop_r1_q;
			stop_r3_q <= stop_r2_q;
			dirty_r1_q <= dirty_q;
			dirty_r2_q <= dirty_r1_q;
		end
	end

	// Counts from the stop closing a write with data
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			busy_q <= 1'b0;
			wr_cnt_q <= '0;
			done_tgl_q <= 1'b0;
			served_q <= 1'b0;
		end
		else if (i_ce)
		begin
			// Mark stays up until the link sees completion; later stops must not start a second cycle
			if (!dirty_r2_q)
				served_q <= 1'b0;
			if (!busy_q && !served_q && (stop_r2_q ^ stop_r3_q) && dirty_r2_q)
			begin
				busy_q <= 1'b1;
				served_q <= 1'b1;
				wr_cnt_q <= '0;
			end
			else if (busy_q && wr_cnt_q == CW'(WR_CYCLES - 1))
			begin
				busy_q <= 1'b0;
				done_tgl_q <= ~done_tgl_q;
			end
			else if (busy_q)
				wr_cnt_q <= wr_cnt_q + 1'b1;
		end
	end

	assign o_write_busy = busy_q;

	// ********************************
	// Assertions
	// ********************************
	AST_ACK_MATCH: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		i_ce && !start_pend && !stop_pend && state_q == ST_DEVADDR && bit_q == BIT_LAST && dev_match && !dirty_q
		|=> ack_q && oe_q)
		else $error("matching address not acknowledged");
	AST_NO_ACK_BUSY: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		i_ce && state_q == ST_DEVADDR && bit_q == BIT_LAST && dirty_q |=> !ack_q)
		else $error("address acknowledged during write cycle");
	AST_READ_ENTRY: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		i_ce && !start_pend && !stop_pend && state_q == ST_DEVADDR && bit_q == BIT_ACK && ack_q && rw_q
		|=> state_q == ST_READ && bit_q == 4'h0 && tx_q == $past(buf_data))
		else $error("read not started after address ack");
	AST_ADDR_INC: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		pop && state_q == ST_READ |=> addr_q == $past(addr_q) + 1'b1 && state_q == ST_READ)
		else $error("counter not advanced on ack");
	AST_WRAP: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		pop && addr_q == '1 |=> addr_q == '0)
		else $error("counter did not wrap to zero");
	AST_NACK_END: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		i_ce && !start_pend && !stop_pend && state_q == ST_READ && bit_q == BIT_ACK && i_sda_in
		|=> state_q == ST_IDLE && addr_q == $past(addr_q))
		else $error("read not ended on no-ack");
	AST_START_ABORT: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		i_ce && start_pend |=> state_q == ST_DEVADDR && bit_q == BIT_FIRST)
		else $error("start did not restart address phase");
	AST_RELEASE: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		state_q == ST_READ && bit_q == BIT_ACK |-> !oe_q)
		else $error("SDA held during controller ack slot");
	AST_TX_BIT: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		state_q == ST_READ && bit_q < BIT_ACK && $stable(bit_q) == 1'b0 |-> oe_q == !tx_q[3'(BIT_LAST - bit_q)])
		else $error("wrong data bit driven");
	AST_WR_TIME: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_ce && busy_q && wr_cnt_q == CW'(WR_CYCLES - 1) |=> !busy_q ##1 done_tgl_q != $past(done_tgl_q, 2))
		else $error("write cycle overran");

	COV_SEQ_READ: cover property (@(posedge i_scl) disable iff (!i_rst_n) pop && state_q == ST_READ);
	COV_WRAP: cover property (@(posedge i_scl) disable iff (!i_rst_n) pop && addr_q == '1);
	COV_BUSY_NACK: cover property (@(posedge i_scl) disable iff (!i_rst_n)
		state_q == ST_DEVADDR && bit_q == BIT_LAST && dirty_q && dev_match);
	COV_WR_DONE: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $fell(busy_q));

endmodule

// >>> sim/sre_ctl_model.sv
// Two-wire bus controller model: drives the link clock and pulls SDA low.
// Assumes a pull-up on SDA; the link clock stands high between frames.
`timescale 1ns/100ps
module sre_ctl_model (
	output logic o_scl,
	output logic o_sda_low,
	input wire logic i_sda,
	input wire logic i_dev_oe
);
	// ******
	// Bit level, 32 ns link clock
	// ******
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Data set early in the low phase, sampled mid high phase
	// Entered with the clock already low
	task automatic xbit(input logic b, output logic r);
		#4 o_sda_low = ~b;
		#12 o_scl = 1'b1;
		#8 r = i_sda;
		#8 o_scl = 1'b0;
	endtask

	// Works from idle and as a repeated start
	task automatic start;
		if (!o_scl)
		begin
			#4 o_sda_low = 1'b0;
			#12 o_scl = 1'b1;
			#8;
		end
		o_sda_low = 1'b1;
		#8 o_scl = 1'b0;
	endtask

	// Leaves the bus idle with both lines high
	task automatic stop;
		#4 o_sda_low = 1'b1;
		#12 o_scl = 1'b1;
		#8 o_sda_low = 1'b0;
		#8;
	endtask

	// ******
	// Byte level
	// ******
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], r);
		xbit(1'b1, r);
		ack = ~r;
	endtask

	// Acks to go on, no-ack before the closing stop
	task automatic rbyte(input logic more, output logic [7:0] d, output logic rel);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xbit(1'b1, r);
			d[i] = r;
		end
		#4 o_sda_low = more;
		#12 o_scl = 1'b1;
		#8 rel = ~i_dev_oe;
		#8 o_scl = 1'b0;
	endtask

	task automatic addr(input logic [2:0] strap, input logic rd, output logic ack);
		start();
		wbyte({4'ha, strap, rd}, ack);
	endtask

	// Address-only write loads the counter, then repeated start for reading
	task automatic seek(input logic [2:0] strap, input logic [14:0] a, output logic ok);
		logic k0, k1, k2, k3;
		addr(strap, 1'b0, k0);
		wbyte({1'b0, a[14:8]}, k1);
		wbyte(a[7:0], k2);
		addr(strap, 1'b1, k3);
		ok = k0 & k1 & k2 & k3;
	endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the serial EEPROM slave with a controller model.
// Assumes a pull-up on SDA; write time shortened through WR_CYCLES.
`timescale 1ns/100ps
module tb_top;
	import sre_pkg::*;
	localparam int WRC = 200;
	logic i_ref_clk, i_rst_n, scl, sda_low, sda, oe, sda_out, busy, k;
	logic [2:0] strap;
	logic [4:0] pre;
	logic [7:0] mem [logic [14:0]];
	int fails, tests_run, seed, j;

	sre_eeprom #(.ADDR_W(ADDR_W), .WR_CYCLES(WRC)) i_dut (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(1'b1),
		.i_scl(scl),
		.i_sda_in(sda),
		.o_sda_out(sda_out),
		.o_sda_oe(oe),
		.i_hardwired_addr_pin_2(strap[2]),
		.i_hardwired_addr_pin_1(strap[1]),
		.i_hardwired_addr_pin_0(strap[0]),
		.o_write_busy(busy)
	);

	sre_ctl_model i_ctl (
		.o_scl(scl),
		.o_sda_low(sda_low),
		.i_sda(sda),
		.i_dev_oe(oe)
	);

	// Wired-AND of both open-drain parties, pull-up when released
	assign sda = ~((oe & ~sda_out) | sda_low);

	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// ******
	// Checking and closing
	// ******
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ******
	// Transfers
	// ******
	// Busy must stand exactly the write time; polls are refused meanwhile
	task automatic wait_write;
		int t, cnt;
		logic pk;
		t = 0;
		cnt = 0;
		while (busy !== 1'b1 && t < 20)
		begin
			@(negedge i_ref_clk);
			t++;
		end
		if (t == 20)
		begin
			fails++;
			summarize();
		end
		fork
			while (busy === 1'b1 && cnt < 2 * WRC)
			begin
				@(negedge i_ref_clk);
				cnt++;
			end
			i_ctl.addr(strap, 1'b1, pk);
		join
		check(pk, 1'b0);
		check(cnt, WRC);
		i_ctl.stop();
		i_ctl.addr(strap, 1'b0, pk);
		i_ctl.stop();
		check(pk, 1'b1);
	endtask

	// Stays inside one page; random data kept as the expectation
	task automatic wr(input logic [14:0] a, input int n);
		logic [7:0] d;
		i_ctl.addr(strap, 1'b0, k);
		check(k, 1'b1);
		i_ctl.wbyte({1'b0, a[14:8]}, k);
		i_ctl.wbyte(a[7:0], k);
		for (int i = 0; i < n; i++)
		begin
			d = 8'($random(seed));
			mem[15'(a + i)] = d;
			i_ctl.wbyte(d, k);
		end
		i_ctl.stop();
		wait_write();
	endtask

	// Random read when sk is set, else current read; n bytes in a row
	task automatic rd(input logic [14:0] a, input int n, input logic sk);
		logic rel;
		logic [7:0] d;
		if (sk)
			i_ctl.seek(strap, a, k);
		else
			i_ctl.addr(strap, 1'b1, k);
		check(k, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			i_ctl.rbyte(i < n - 1, d, rel);
			check(d, mem[15'(a + i)]);
			check(rel, 1'b1);
		end
		i_ctl.stop();
		@(negedge i_ref_clk);
		check(oe, 1'b0);
	endtask

	// ******
	// Main sequence
	// ******
	initial
	begin
		seed = 31;
		fails = 0;
		tests_run = 0;
		strap = 3'($random(seed));
		i_rst_n = 1'b0;
		repeat (20) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		@(negedge i_ref_clk);
		check(busy, 1'b0);
		check(oe, 1'b0);
		wr(15'h7ffe, 2);
		wr(15'h0000, 2);
		// Sequential read across the top of memory
		rd(15'h7ffe, 3, 1'b1);
		// Start in mid-address must drop that byte, counter kept
		pre = {4'ha, strap[2]};
		i_ctl.start();
		for (int i = 4; i >= 0; i--)
			i_ctl.xbit(pre[i], k);
		rd(15'h0001, 1, 1'b0);
		// Foreign strap and foreign device type get no acknowledge
		i_ctl.addr(~strap, 1'b1, k);
		check(k, 1'b0);
		i_ctl.stop();
		i_ctl.start();
		i_ctl.wbyte({4'hb, strap, 1'b1}, k);
		check(k, 1'b0);
		i_ctl.stop();
		// Random start points within the written bytes
		repeat (4)
		begin
			j = {$random(seed)} % 4;
			rd(15'(15'h7ffe + j), 4 - j, 1'b1);
		end
		// Current read from the counter left by a one-byte random read, across the top
		rd(15'h7ffe, 1, 1'b1);
		rd(15'h7fff, 3, 1'b0);
		summarize();
	end
endmodule
